// *** rtl/spg_pm_event.sv ***
// module: mgmt/control interrupt generation and sleep power outputs
`timescale 1ns/100ps
`default_nettype none
module spg_pm_event (
   input  wire logic                        clk,               // 200 MHz clock
   input  wire logic                        rst_b,             // sync reset, active low
   input  wire logic                        hsel,              // ahb select
   input  wire logic [31:0]                 haddr,             // ahb address
   input  wire logic [1:0]                  htrans,            // ahb transfer type
   input  wire logic                        hwrite,            // ahb write
   input  wire logic [2:0]                  hsize,             // ahb size
   input  wire logic [31:0]                 hwdata,            // ahb write data
   input  wire logic                        hready,            // ahb bus ready
   output logic      [31:0]                 hrdata,            // ahb read data
   output logic                             hreadyout,         // ahb slave ready
   output logic                             hresp,             // ahb response, okay
   input  wire logic [spg_pkg::NUM_SRC-1:0] eventIn,           // async source events
   output logic                             virtualWireMessage, // mgmt irq message pulse
   output logic [spg_pkg::NUM_LINE-1:0]     irqLineOut,        // control irq lines
   output logic                             s3SleepOut,        // high = asserted
   output logic                             s4SleepOut,        // high = asserted
   output logic                             s5SleepOut,        // high = asserted
   output logic                             enginePowerOffOut, // high = asserted
   output logic                             networkPowerOffOut, // high = asserted
   output logic                             suspendWellOffOut, // high = asserted
   output logic                             irqOut             // block interrupt level
);
   // ==========================================================
   // state
   logic [spg_pkg::NUM_SRC-1:0]   evSync1_reg, evSync2_reg;
   logic [spg_pkg::NUM_SRC-1:0]   srcSts_reg, srcEn_reg;
   logic                          selBit_reg, gblEn_reg, apic_reg, rearm_reg;
   logic [2:0]                    route_reg;
   logic [1:0]                    sleep_reg;
   logic                          engOff_reg, hostWol_reg, engWol_reg, susOff_reg;
   logic [spg_pkg::NUM_IRQEV-1:0] irqSts_reg, irqEn_reg;
   logic                          dWr_reg, dRd_reg;
   logic [7:0]                    dAddr_reg;
   logic                          sciLevel_reg;
   logic                          pendSmi, pendSci, smiFire;
   logic                          wrStb, rdStb;
   logic [2:0]                    lineIdx;
   logic [spg_pkg::NUM_IRQEV-1:0] irqEvent;
   logic [spg_pkg::NUM_SRC-1:0]   stsClr;

   // ==========================================================
   // bus decode helpers
   function automatic logic isReg(input logic [7:0] a, input logic [7:0] off);
      isReg = (a == off);
   endfunction

   // address phase accepted only when bus is ready and transfer is active
   assign rdStb = hsel && hready && htrans[1] && !hwrite;
   assign wrStb = dWr_reg;

   // ==========================================================
   // two-flop synchroniser for external event pins
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         evSync1_reg <= '0;
         evSync2_reg <= '0;
      end else begin
         evSync1_reg <= eventIn;
         evSync2_reg <= evSync1_reg;
      end
   end

   // ==========================================================
   // pending conditions
   // select bit steers each enabled source to at most one interrupt type; a source without that type's capability raises neither
   assign pendSci = selBit_reg && |(srcSts_reg & srcEn_reg & spg_pkg::SRC_SCI_CAP);
   assign pendSmi = !selBit_reg && gblEn_reg
                    && |(srcSts_reg & srcEn_reg & spg_pkg::SRC_SMI_CAP);
   assign smiFire = pendSmi && rearm_reg;

   // ==========================================================
   // data phase latch; zero wait states, so hreadyout stays high
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         dWr_reg   <= 1'b0;
         dRd_reg   <= 1'b0;
         dAddr_reg <= 8'h00;
      end else begin
         dWr_reg   <= hsel && hready && htrans[1] && hwrite;
         dRd_reg   <= rdStb;
         dAddr_reg <= haddr[7:0];
      end
   end

   // ==========================================================
   // source status: sticky, write one to clear, new event beats clear
   assign stsClr = (wrStb && isReg(dAddr_reg, spg_pkg::SRC_STS_OFF))
                   ? hwdata[spg_pkg::NUM_SRC-1:0] : '0;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         srcSts_reg <= '0;
      end else begin
         srcSts_reg <= (srcSts_reg & ~stsClr) | evSync2_reg;
      end
   end

   // ==========================================================
   // software-written configuration
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         srcEn_reg   <= '0;
         selBit_reg  <= 1'b0;
         gblEn_reg   <= 1'b0;
         apic_reg    <= 1'b0;
         route_reg   <= 3'h0;
         sleep_reg   <= 2'h0;
         engOff_reg  <= 1'b0;
         hostWol_reg <= 1'b0;
         engWol_reg  <= 1'b0;
         susOff_reg  <= 1'b0;
         irqEn_reg   <= '0;
      end else if (wrStb) begin
         if (isReg(dAddr_reg, spg_pkg::SRC_EN_OFF)) begin
            srcEn_reg <= hwdata[spg_pkg::NUM_SRC-1:0];
         end
         if (isReg(dAddr_reg, spg_pkg::CTRL_OFF)) begin
            selBit_reg <= hwdata[spg_pkg::CTRL_SEL_BIT];
            gblEn_reg  <= hwdata[spg_pkg::CTRL_GBL_BIT];
            apic_reg   <= hwdata[spg_pkg::CTRL_APIC_BIT];
            route_reg  <= hwdata[spg_pkg::CTRL_ROUTE_LSB +: spg_pkg::CTRL_ROUTE_W];
         end
         if (isReg(dAddr_reg, spg_pkg::SLEEP_OFF)) begin
            sleep_reg   <= hwdata[spg_pkg::SLP_STATE_LSB +: 2];
            engOff_reg  <= hwdata[spg_pkg::SLP_ENGOFF_BIT];
            hostWol_reg <= hwdata[spg_pkg::SLP_HOSTWOL_BIT];
            engWol_reg  <= hwdata[spg_pkg::SLP_ENGWOL_BIT];
            susOff_reg  <= hwdata[spg_pkg::SLP_SUSOFF_BIT];
         end
         if (isReg(dAddr_reg, spg_pkg::IRQ_EN_OFF)) begin
            irqEn_reg <= hwdata[spg_pkg::NUM_IRQEV-1:0];
         end
      end
   end

   // ==========================================================
   // handler re-arm: hardware clears on send; a software set in the same
   // cycle as a send loses, since that send already serviced the events
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rearm_reg <= spg_pkg::REARM_RST;
      end else if (smiFire) begin
         rearm_reg <= 1'b0;
      end else if (wrStb && isReg(dAddr_reg, spg_pkg::CTRL_OFF)
                   && hwdata[spg_pkg::CTRL_REARM_BIT]) begin
         rearm_reg <= 1'b1;
      end
   end

   // ==========================================================
   // mgmt interrupt leaves as a one-cycle message pulse, no dedicated pin
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         virtualWireMessage <= 1'b0;
      end else begin
         virtualWireMessage <= smiFire;
      end
   end

   // ==========================================================
   // control interrupt routing; out-of-range index falls back to line 0
   always_comb begin
      lineIdx = route_reg;
      if (!apic_reg && route_reg > spg_pkg::LEGACY_MAXIDX) begin
         lineIdx = 3'h0;
      end else if (route_reg > spg_pkg::APIC_MAXIDX) begin
         lineIdx = 3'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sciLevel_reg <= 1'b0;
      end else begin
         sciLevel_reg <= pendSci;
      end
   end

   // shared lines idle high and assert low, others assert high
   genvar g;
   generate
      for (g = 0; g < spg_pkg::NUM_LINE; g++) begin : gLine
         always_ff @(posedge clk) begin
            if (!rst_b) begin
               irqLineOut[g] <= spg_pkg::LINE_SHARED[g];
            end else begin
               irqLineOut[g] <= spg_pkg::LINE_SHARED[g]
                                ^ (pendSci && lineIdx == 3'(g));
            end
         end
      end
   endgenerate

   // ==========================================================
   // sleep and power plane outputs
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s3SleepOut         <= 1'b0;
         s4SleepOut         <= 1'b0;
         s5SleepOut         <= 1'b0;
         enginePowerOffOut  <= 1'b0;
         networkPowerOffOut <= 1'b0;
         suspendWellOffOut  <= 1'b0;
      end else begin
         s3SleepOut         <= sleep_reg != 2'(spg_pkg::SLP_S0);
         s4SleepOut         <= sleep_reg == 2'(spg_pkg::S4_SLEEP_OUT)
                               || sleep_reg == 2'(spg_pkg::S5_SLEEP_OUT);
         s5SleepOut         <= sleep_reg == 2'(spg_pkg::S5_SLEEP_OUT);
         enginePowerOffOut  <= engOff_reg;
         networkPowerOffOut <= (sleep_reg != 2'(spg_pkg::SLP_S0) || engOff_reg)
                               && !hostWol_reg && !engWol_reg;
         suspendWellOffOut  <= susOff_reg
                               && sleep_reg != 2'(spg_pkg::SLP_S0);
      end
   end

   // ==========================================================
   // block interrupt: sticky events, set wins over clear
   assign irqEvent[spg_pkg::EV_SMI_SENT] = smiFire;
   assign irqEvent[spg_pkg::EV_SCI_RISE] = pendSci && !sciLevel_reg;
   assign irqEvent[spg_pkg::EV_SLP_CHG]  = wrStb && isReg(dAddr_reg, spg_pkg::SLEEP_OFF)
                                           && hwdata[spg_pkg::SLP_STATE_LSB +: 2] != sleep_reg;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         irqSts_reg <= '0;
         irqOut     <= 1'b0;
      end else begin
         if (wrStb && isReg(dAddr_reg, spg_pkg::IRQ_CLR_OFF)) begin
            irqSts_reg <= (irqSts_reg & ~hwdata[spg_pkg::NUM_IRQEV-1:0]) | irqEvent;
         end else begin
            irqSts_reg <= irqSts_reg | irqEvent;
         end
         irqOut <= |(irqSts_reg & irqEn_reg);
      end
   end

   // ==========================================================
   // read data registered in the address phase, stands in the data phase
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
         if (rdStb) begin
            case (haddr[7:0])
               spg_pkg::CTRL_OFF:    hrdata <= {25'h0, route_reg, rearm_reg,
                                                apic_reg, gblEn_reg, selBit_reg};
               spg_pkg::SRC_STS_OFF: hrdata <= {24'h0, srcSts_reg};
               spg_pkg::SRC_EN_OFF:  hrdata <= {24'h0, srcEn_reg};
               spg_pkg::SLEEP_OFF:   hrdata <= {26'h0, susOff_reg, engWol_reg,
                                                hostWol_reg, engOff_reg, sleep_reg};
               spg_pkg::IRQ_STS_OFF: hrdata <= {29'h0, irqSts_reg};
               spg_pkg::IRQ_EN_OFF:  hrdata <= {29'h0, irqEn_reg};
               default:              hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ==========================================================
   // checks
   AST_SMI_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
      smiFire |=> virtualWireMessage && !rearm_reg)
      else $error("mgmt message or rearm clear missing");

   AST_SMI_ONE: assert property (@(posedge clk) disable iff (!rst_b)
      virtualWireMessage |=> !virtualWireMessage)
      else $error("mgmt message longer than one cycle");

   AST_SMI_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
      !rearm_reg && !(wrStb && isReg(dAddr_reg, spg_pkg::CTRL_OFF)) |=> !virtualWireMessage [*2])
      else $error("mgmt message sent while not rearmed");

   AST_REARM_RESEND: assert property (@(posedge clk) disable iff (!rst_b)
      !rearm_reg && pendSmi && wrStb && isReg(dAddr_reg, spg_pkg::CTRL_OFF)
      && hwdata[spg_pkg::CTRL_REARM_BIT] && !hwdata[spg_pkg::CTRL_SEL_BIT]
      && hwdata[spg_pkg::CTRL_GBL_BIT] |=> ##1 virtualWireMessage)
      else $error("rearm with pending events did not resend");

   AST_SCI_LEVEL: assert property (@(posedge clk) disable iff (!rst_b)
      pendSci |=> (irqLineOut ^ spg_pkg::LINE_SHARED) != 7'h00)
      else $error("control irq level dropped while source active");

   AST_LEGACY_ROUTE: assert property (@(posedge clk) disable iff (!rst_b)
      !$past(apic_reg) |-> ((irqLineOut ^ spg_pkg::LINE_SHARED) & 7'h78) == 7'h00)
      else $error("legacy route outside lines 9 to 11");

   AST_POLARITY: assert property (@(posedge clk) disable iff (!rst_b)
      !pendSci |=> irqLineOut == spg_pkg::LINE_SHARED)
      else $error("idle line level wrong for its sharing");

   AST_GBL_OFF: assert property (@(posedge clk) disable iff (!rst_b)
      !gblEn_reg |-> !smiFire)
      else $error("mgmt interrupt without global enable");

   AST_SELECT: assert property (@(posedge clk) disable iff (!rst_b)
      !(pendSci && pendSmi))
      else $error("both interrupt types pending");

   AST_NET_OFF: assert property (@(posedge clk) disable iff (!rst_b)
      (hostWol_reg || engWol_reg) |=> !networkPowerOffOut)
      else $error("network off with wake-on-lan");

   AST_S5_IMPL: assert property (@(posedge clk) disable iff (!rst_b)
      s5SleepOut |-> s4SleepOut && s3SleepOut)
      else $error("s5 without s4 and s3");
endmodule
`default_nettype wire

// *** rtl/spg_pkg.sv ***
// package: register map, fields and constants of the sleep output and smi/sci block
package spg_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [7:0] CTRL_OFF    = 8'h00;
   localparam logic [7:0] SRC_STS_OFF = 8'h04;
   localparam logic [7:0] SRC_EN_OFF  = 8'h08;
   localparam logic [7:0] SLEEP_OFF   = 8'h0C;
   localparam logic [7:0] IRQ_STS_OFF = 8'h10;
   localparam logic [7:0] IRQ_CLR_OFF = 8'h14;
   localparam logic [7:0] IRQ_EN_OFF  = 8'h18;

   // ==========================================================
   // sizes
   localparam int NUM_SRC   = 8;
   localparam int NUM_LINE  = 7;
   localparam int NUM_IRQEV = 3;

   // ==========================================================
   // control register fields
   localparam int CTRL_SEL_BIT    = 0;  // interrupt select: 1 control irq, 0 mgmt irq
   localparam int CTRL_GBL_BIT    = 1;  // global mgmt irq enable
   localparam int CTRL_APIC_BIT   = 2;  // advanced interrupt controller in use
   localparam int CTRL_REARM_BIT  = 3;  // handler re-arm, write 1 sets
   localparam int CTRL_ROUTE_LSB  = 4;  // 3-bit route index
   localparam int CTRL_ROUTE_W    = 3;

   // ==========================================================
   // sleep register fields
   localparam int SLP_STATE_LSB   = 0;  // 2-bit target state
   localparam int SLP_ENGOFF_BIT  = 2;
   localparam int SLP_HOSTWOL_BIT = 3;
   localparam int SLP_ENGWOL_BIT  = 4;
   localparam int SLP_SUSOFF_BIT  = 5;

   // ==========================================================
   // interrupt status events
   localparam int EV_SMI_SENT  = 0;
   localparam int EV_SCI_RISE  = 1;
   localparam int EV_SLP_CHG   = 2;

   // ==========================================================
   // source capabilities and routing lines (index 0..6 = irq 9,10,11,20,21,22,23)
   localparam logic [NUM_SRC-1:0]  SRC_SCI_CAP   = 8'h0F;
   localparam logic [NUM_SRC-1:0]  SRC_SMI_CAP   = 8'hFC;
   localparam logic [NUM_LINE-1:0] LINE_SHARED   = 7'h78;  // lines shared with pci irq
   localparam logic [2:0]          LEGACY_MAXIDX = 3'h2;
   localparam logic [2:0]          APIC_MAXIDX   = 3'h6;
   localparam logic                REARM_RST     = 1'b1;

   typedef enum logic [1:0] {SLP_S0, S3_SLEEP_OUT, S4_SLEEP_OUT, S5_SLEEP_OUT} spg_sleep_e;
endpackage

// *** dv/spg_host_model.sv ***
// far-side model: processor message counter and interrupt controller line decoder
`timescale 1ns/100ps
`default_nettype none
module spg_host_model (
   input  wire logic                         clk,        // system clock
   input  wire logic                         rst_b,      // sync reset, active low
   input  wire logic                         vwMsg,      // mgmt irq message pulse
   input  wire logic [spg_pkg::NUM_LINE-1:0] lineIn,     // control irq lines
   output logic      [spg_pkg::NUM_LINE-1:0] lineActive, // decoded levels, high = active
   output var int                            msgCnt      // messages taken by processor
);
   // ==========================================================
   // decode
   // shared lines idle high, so undo the inversion before comparing
   assign lineActive = lineIn ^ spg_pkg::LINE_SHARED;

   // one message per pulse cycle; a stuck pulse shows as a runaway count
   always_ff @(posedge clk) begin
      if (!rst_b)
         msgCnt <= 0;
      else if (vwMsg)
         msgCnt <= msgCnt + 1;
   end
endmodule
`default_nettype wire

// *** dv/spg_pm_event_tb.sv ***
// testbench: register bus, mgmt and control interrupts, sleep outputs
`timescale 1ns/100ps
`default_nettype none
module spg_pm_event_tb;
   logic        clk, rst_b, hsel, hwrite, hready, hreadyout, hresp, vwMsg, irqOut, rdPhase;
   logic [31:0] haddr, hwdata, hrdata, rnd;
   logic [1:0]  htrans;
   logic [7:0]  eventIn;
   logic [6:0]  lineOut, lineAct;
   logic        s3, s4, s5, engOff, netOff, susOff;
   logic [5:0]  slp, expSlp;
   int          msgCnt, errorCnt, comparisons;
   logic [31:0] expQ[$];

   // ==========================================================
   // design and far side
   assign hready = hreadyout;  // single slave drives bus ready
   spg_pm_event dut_u (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .eventIn(eventIn),
      .virtualWireMessage(vwMsg), .irqLineOut(lineOut), .s3SleepOut(s3), .s4SleepOut(s4),
      .s5SleepOut(s5), .enginePowerOffOut(engOff), .networkPowerOffOut(netOff),
      .suspendWellOffOut(susOff), .irqOut(irqOut));
   spg_host_model host_u (.clk(clk), .rst_b(rst_b), .vwMsg(vwMsg), .lineIn(lineOut),
      .lineActive(lineAct), .msgCnt(msgCnt));

   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ==========================================================
   // helpers
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errorCnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // one single transfer; waits on ready in both phases, with no limit of its own
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h00, a};
      hwrite <= wr;
      do @(posedge clk); while (!hreadyout);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (!hreadyout);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   // the expected value is noted first, the monitor compares it
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      expQ.push_back(exp);
      bus(1'b0, a, 32'h00000000);
   endtask

   // one-cycle event; six cycles cover sync, status and message
   task automatic pulse(input int s);
      eventIn[s] <= 1'b1;
      cyc(1);
      eventIn <= 8'h00;
      cyc(6);
   endtask

   // read data stand in the data phase and are taken at its closing edge
   always @(posedge clk) begin
      if (rdPhase && hreadyout)
         chk(hrdata, expQ.pop_front());
      rdPhase <= hsel && htrans[1] && !hwrite && hreadyout;
   end

   task automatic endSim();
      $display("comparisons=%0d mismatches=%0d", comparisons, errorCnt);
      if (errorCnt == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // hang guard, far beyond the few hundred cycles the run needs
   initial begin
      #100000;
      errorCnt++;
      endSim();
   end

   // ==========================================================
   // main sequence
   initial begin
      rst_b = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'h0;
      haddr = 32'h00000000;
      hwdata = 32'h00000000;
      eventIn = 8'h00;
      rnd = 32'h3F81C46E;
      cyc(3);
      rst_b <= 1'b1;
      cyc(1);
      chk(32'(lineOut), 32'h78);
      chk(32'(hresp), 32'h0);
      rd(spg_pkg::CTRL_OFF, 32'h8);
      rd(spg_pkg::SRC_STS_OFF, 32'h0);
      rd(8'h1C, 32'h0);
      $display("test reset done");

      // mgmt interrupt: global gate, rearm gate, resend on rearm
      wr(spg_pkg::SRC_EN_OFF, 32'h04);
      pulse(2);
      chk(32'(msgCnt), 32'h0);
      rd(spg_pkg::SRC_STS_OFF, 32'h4);
      wr(spg_pkg::CTRL_OFF, 32'hA);
      cyc(4);
      chk(32'(msgCnt), 32'h1);
      rd(spg_pkg::CTRL_OFF, 32'h2);
      pulse(2);
      chk(32'(msgCnt), 32'h1);
      wr(spg_pkg::CTRL_OFF, 32'hA);
      cyc(4);
      chk(32'(msgCnt), 32'h2);
      wr(spg_pkg::SRC_STS_OFF, 32'h4);
      wr(spg_pkg::CTRL_OFF, 32'hA);
      cyc(4);
      chk(32'(msgCnt), 32'h2);
      $display("test mgmt done");

      // block interrupt: raise, mask, clear
      rd(spg_pkg::IRQ_STS_OFF, 32'h1);
      chk(32'(irqOut), 32'h0);
      wr(spg_pkg::IRQ_EN_OFF, 32'h1);
      cyc(2);
      chk(32'(irqOut), 32'h1);
      wr(spg_pkg::IRQ_EN_OFF, 32'h0);
      cyc(2);
      chk(32'(irqOut), 32'h0);
      wr(spg_pkg::IRQ_EN_OFF, 32'h7);
      wr(spg_pkg::IRQ_CLR_OFF, 32'h1);
      cyc(2);
      chk(32'(irqOut), 32'h0);
      rd(spg_pkg::IRQ_STS_OFF, 32'h0);
      rd(spg_pkg::IRQ_CLR_OFF, 32'h0);
      $display("test irq done");

      // select bit sends the dual source to the control line instead
      wr(spg_pkg::CTRL_OFF, 32'hB);
      pulse(2);
      chk(32'(msgCnt), 32'h2);
      chk(32'(lineAct), 32'h1);
      chk(32'(irqOut), 32'h1);
      wr(spg_pkg::SRC_STS_OFF, 32'h4);
      cyc(3);
      chk(32'(lineAct), 32'h0);
      // routing over every line while source 0 is held active
      wr(spg_pkg::SRC_EN_OFF, 32'h01);
      eventIn[0] <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         wr(spg_pkg::CTRL_OFF, 32'h5 | 32'(i << 4));
         cyc(4);
         chk(32'(lineAct), (i > 6) ? 32'h1 : 32'(1 << i));
      end
      for (int i = 0; i < 4; i++) begin
         wr(spg_pkg::CTRL_OFF, 32'h1 | 32'(i << 4));
         cyc(4);
         chk(32'(lineAct), (i > 2) ? 32'h1 : 32'(1 << i));
      end
      wr(spg_pkg::SRC_STS_OFF, 32'h1);
      cyc(3);
      chk(32'(lineAct), 32'h1);
      eventIn <= 8'h00;
      cyc(3);
      wr(spg_pkg::SRC_STS_OFF, 32'h1);
      cyc(3);
      chk(32'(lineAct), 32'h0);
      $display("test control done");

      // random sleep settings against the output equations
      for (int k = 0; k < 12; k++) begin
         rnd = lfsr(rnd);
         slp = rnd[5:0];
         wr(spg_pkg::SLEEP_OFF, {26'h0, slp});
         cyc(2);
         expSlp = {slp[1:0] != 2'h0, slp[1], slp[1:0] == 2'h3, slp[2],
                   (slp[1:0] != 2'h0 || slp[2]) && !slp[3] && !slp[4],
                   slp[5] && slp[1:0] != 2'h0};
         chk({26'h0, s3, s4, s5, engOff, netOff, susOff}, {26'h0, expSlp});
      end
      $display("test sleep done");
      cyc(3);
      endSim();
   end
endmodule
`default_nettype wire
